// ---- hdl/frt_defines.vh ----
/*
 * Register offsets, field positions, reset values and timing counts for the
 * free-running timer with input capture.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
`ifndef FRT_DEFINES_VH
`define FRT_DEFINES_VH

`define FRT_OFS_COUNT_MSB      12'h000
`define FRT_OFS_COUNT_LSB      12'h004
`define FRT_OFS_ALT_COUNT_MSB  12'h008
`define FRT_OFS_ALT_COUNT_LSB  12'h00C
`define FRT_OFS_CAP1_MSB       12'h010
`define FRT_OFS_CAP1_LSB       12'h014
`define FRT_OFS_CAP2_MSB       12'h018
`define FRT_OFS_CAP2_LSB       12'h01C
`define FRT_OFS_STATUS         12'h020
`define FRT_OFS_CTRL_ONE       12'h024
`define FRT_OFS_CTRL_TWO       12'h028
`define FRT_OFS_CTRL_THREE     12'h02C

// Status register bits
`define FRT_SR_CAP1            7
`define FRT_SR_CAP2            6
`define FRT_SR_OVF             5
// Control one bits
`define FRT_C1_CAP_IE          7
`define FRT_C1_OVF_IE          5
`define FRT_C1_EDGE_ONE        1
// Control two bits
`define FRT_C2_CLK_SEL1        3
`define FRT_C2_CLK_SEL0        2
`define FRT_C2_EDGE_TWO        1
`define FRT_C2_EXT_EDGE        0
// Control three bits
`define FRT_C3_GLOBAL_IE       7
`define FRT_C3_HALT            0

`define FRT_RESET_CTRL         8'h00
`define FRT_COUNT_RESET        16'hFFFC
`define FRT_EXT_MIN_GAP        4

`endif

// ---- hdl/frt_edge_det.v ----
/*
 * Edge detector for a pin sampled on the system clock.
 * Assumes the pin is already synchronous to the clock.
 */
`timescale 1ns/10ps
module frt_edge_det (
    input  wire I_CLK_SYS,
    input  wire I_RESET_N,
    input  wire i_pin,
    input  wire i_rising,
    output wire o_edge
);
    reg pin_reg;

    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= i_pin;
        end
    end

    assign o_edge = i_rising ? (i_pin & ~pin_reg) : (~i_pin & pin_reg);
endmodule // frt_edge_det

// ---- hdl/frt_timer.v ----
/*
 * Free-running 16-bit counter with prescaler, external clock, overflow flag,
 * buffered byte reads and two input-capture channels, behind an APB slave.
 * Assumes pins are synchronous to I_CLK_SYS; compare logic lives elsewhere and
 * feeds its own request into O_IRQ through I_COMPARE_IRQ.
 */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "frt_defines.vh"

// Contract
// [R1] Counter steps on internal clock divided by 2, 4 or 8 per clock bits.
// [R2] Writing either counter low byte loads FFFC into the counter.
// [R3] Primary and alternate counter pairs are read-only views of one count.
// [R4] High byte read latches low byte until low byte is read.
// [R5] After a completed sequence, lone low-byte reads return live count.
// [R6] Wrap from FFFF to 0000 sets the overflow flag.
// [R7] Overflow raises interrupt only with its enable and global enable set.
// [R8] Overflow cleared by status read while set, then counter low access.
// [R9] Alternate low-byte accesses never clear the overflow flag.
// [R10] Counter keeps running in wait mode.
// [R11] Halt stops counter; leaving halt restarts from reset count.
// [R12] Both clock bits set selects external clock pin.
// [R13] Edge select bit picks rising or falling external clock edges.
// [R14] External active edges at least four internal clocks apart.
// [R15] Capture pin edge copies count to capture register and sets flag.
// [R16] Each capture channel has its own edge select bit.
// [R17] Capture raises interrupt only with capture and global enables set.
// [R18] Capture flag cleared by status read while set, then capture low access.
// [R19] Capture high read blocks captures until capture low read.
// [R20] Capture register holds value of most recent capture.
// [R21] Overflow, captures and compares share one interrupt output.
// [R22] Simultaneous overflow and capture events each set their flags.
module frt_timer (
    input  wire        I_CLK_SYS,
    input  wire        I_RESET_N,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [11:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire        O_PREADY,
    output wire        O_PSLVERR,
    input  wire        I_EXT_CLOCK_PIN,
    input  wire        I_CAPTURE_PIN_ONE,
    input  wire        I_CAPTURE_PIN_TWO,
    input  wire        I_WAIT_MODE,
    input  wire        I_COMPARE_IRQ,
    output wire [15:0] O_COUNT,
    output wire        O_IRQ
);
    localparam CW = 16;

    // Counter and its buffered low byte

    reg [CW-1:0] count_reg;
    reg [7:0]    lsb_buf_reg;
    reg          lsb_held_reg;

    // Capture channels
    reg [CW-1:0] cap1_reg;
    reg [CW-1:0] cap2_reg;
    reg [7:0]    cap1_lsb_reg;
    reg [7:0]    cap2_lsb_reg;
    reg          cap1_block_reg;
    reg          cap2_block_reg;

    // Flags and their clear arming
    reg          ovf_flag_reg;
    reg          cap1_flag_reg;
    reg          cap2_flag_reg;
    reg          ovf_armed_reg;
    reg          cap1_armed_reg;
    reg          cap2_armed_reg;
    reg [7:0]    ctrl_one_reg;
    reg [7:0]    ctrl_two_reg;
    reg [7:0]    ctrl_three_reg;

    // Prescaler, halt history and bus data
    reg [2:0]    div_reg;
    reg          halt_d_reg;
    reg [31:0]   prdata_reg;

    // APB decode
    wire access   = I_PSEL & I_PENABLE;
    wire wr       = access & I_PWRITE;
    wire rd       = access & ~I_PWRITE;
    // Byte buffers latch at the setup edge, the same edge that samples read data
    wire rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    wire halt     = ctrl_three_reg[`FRT_C3_HALT];
    wire ext_sel  = ctrl_two_reg[`FRT_C2_CLK_SEL1] & ctrl_two_reg[`FRT_C2_CLK_SEL0]; // [R12]
    wire ext_edge;
    wire cap1_edge;
    wire cap2_edge;
    reg  tick;

    function hit;
        input [11:0] ofs;
        begin
            hit = (I_PADDR == ofs);
        end
    endfunction

    // Decoded accesses

    wire acc_lsb     = access & hit(`FRT_OFS_COUNT_LSB);
    wire acc_alt_lsb = access & hit(`FRT_OFS_ALT_COUNT_LSB);
    wire rd_msb      = rd_setup & (hit(`FRT_OFS_COUNT_MSB) | hit(`FRT_OFS_ALT_COUNT_MSB));
    wire rd_lsb      = rd & (hit(`FRT_OFS_COUNT_LSB) | hit(`FRT_OFS_ALT_COUNT_LSB));
    wire acc_c1_lsb  = access & hit(`FRT_OFS_CAP1_LSB);
    wire acc_c2_lsb  = access & hit(`FRT_OFS_CAP2_LSB);
    wire rd_status   = rd & hit(`FRT_OFS_STATUS);
    wire mapped      = hit(`FRT_OFS_COUNT_MSB) | hit(`FRT_OFS_COUNT_LSB) | hit(`FRT_OFS_ALT_COUNT_MSB)
                     | hit(`FRT_OFS_ALT_COUNT_LSB) | hit(`FRT_OFS_CAP1_MSB) | hit(`FRT_OFS_CAP1_LSB)
                     | hit(`FRT_OFS_CAP2_MSB) | hit(`FRT_OFS_CAP2_LSB) | hit(`FRT_OFS_STATUS)
                     | hit(`FRT_OFS_CTRL_ONE) | hit(`FRT_OFS_CTRL_TWO) | hit(`FRT_OFS_CTRL_THREE);

    // Pin edge detectors; each sees the previous pin sample
    frt_edge_det u_ext (
        .I_CLK_SYS (I_CLK_SYS),
        .I_RESET_N (I_RESET_N),
        .i_pin     (I_EXT_CLOCK_PIN),
        .i_rising  (ctrl_two_reg[`FRT_C2_EXT_EDGE]),                 // [R13]
        .o_edge    (ext_edge)
    );

    frt_edge_det u_cap1 (
        .I_CLK_SYS (I_CLK_SYS),
        .I_RESET_N (I_RESET_N),
        .i_pin     (I_CAPTURE_PIN_ONE),
        .i_rising  (ctrl_one_reg[`FRT_C1_EDGE_ONE]),                 // [R16]
        .o_edge    (cap1_edge)
    );

    frt_edge_det u_cap2 (
        .I_CLK_SYS (I_CLK_SYS),
        .I_RESET_N (I_RESET_N),
        .i_pin     (I_CAPTURE_PIN_TWO),
        .i_rising  (ctrl_two_reg[`FRT_C2_EDGE_TWO]),                 // [R16]
        .o_edge    (cap2_edge)
    );

    // Timer tick: one system clock stands for one internal clock period
    // External edges pass straight through; the source keeps them apart
    always @* begin
        case (ctrl_two_reg[`FRT_C2_CLK_SEL1:`FRT_C2_CLK_SEL0])
            2'b00:   tick = (div_reg[0] == 1'b1);                     // [R1]
            2'b01:   tick = (div_reg[1:0] == 2'b11);                  // [R1]
            2'b10:   tick = (div_reg == 3'b111);                      // [R1]
            default: tick = ext_edge;                                 // [R12] [R14]
        endcase
    end

    // Wait mode is deliberately not an input to the counter path
    wire run  = ~halt;                                                // [R10] [R11]
    wire step = run & tick;
    // Overflow is a step taken from the all-ones count
    wire wrap = step & (count_reg == 16'hFFFF);                       // [R6]

    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            div_reg    <= 3'b000;
            halt_d_reg <= 1'b0;
            count_reg  <= `FRT_COUNT_RESET;
        end else begin
            halt_d_reg <= halt;
            div_reg    <= halt ? 3'b000 : div_reg + 3'd1;
            // Halt holds the restart value so leaving it resumes from there
            if ((wr & (acc_lsb | acc_alt_lsb)) | halt) begin
                count_reg <= `FRT_COUNT_RESET;                        // [R2] [R11]
            end else if (step) begin
                count_reg <= count_reg + 16'd1;                       // [R1]
            end
        end
    end

    // Buffered low byte, shared by primary and alternate views
    // Repeated high-byte reads keep the first latched byte
    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lsb_buf_reg  <= 8'h00;
            lsb_held_reg <= 1'b0;
        end else if (rd_msb & ~lsb_held_reg) begin
            lsb_buf_reg  <= count_reg[7:0];                           // [R4]
            lsb_held_reg <= 1'b1;
        end else if (rd_lsb) begin
            lsb_held_reg <= 1'b0;                                     // [R5]
        end
    end

    // Capture channels; a blocked channel drops its transfer
    // High-byte read latches the low byte so both halves match
    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            cap1_reg       <= 16'h0000;
            cap2_reg       <= 16'h0000;
            cap1_lsb_reg   <= 8'h00;
            cap2_lsb_reg   <= 8'h00;
            cap1_block_reg <= 1'b0;
            cap2_block_reg <= 1'b0;
        end else begin
            if (cap1_edge & ~cap1_block_reg) begin
                cap1_reg <= count_reg;                                // [R15] [R20]
            end
            if (cap2_edge & ~cap2_block_reg) begin
                cap2_reg <= count_reg;                                // [R15] [R20]
            end

            if (rd_setup & hit(`FRT_OFS_CAP1_MSB)) begin
                cap1_block_reg <= 1'b1;                               // [R19]
                cap1_lsb_reg   <= cap1_reg[7:0];
            end else if (rd & acc_c1_lsb) begin
                cap1_block_reg <= 1'b0;                               // [R19]
            end
            if (rd_setup & hit(`FRT_OFS_CAP2_MSB)) begin
                cap2_block_reg <= 1'b1;                               // [R19]
                cap2_lsb_reg   <= cap2_reg[7:0];
            end else if (rd & acc_c2_lsb) begin
                cap2_block_reg <= 1'b0;                               // [R19]
            end
        end
    end

    // Flags: status read arms the clear, low-byte access completes it; a set wins
    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ovf_flag_reg   <= 1'b0;
            cap1_flag_reg  <= 1'b0;
            cap2_flag_reg  <= 1'b0;
            ovf_armed_reg  <= 1'b0;
            cap1_armed_reg <= 1'b0;
            cap2_armed_reg <= 1'b0;
        end else begin
            if (wrap) begin
                ovf_flag_reg <= 1'b1;                                 // [R6] [R22]
            end else if (ovf_armed_reg & acc_lsb) begin
                ovf_flag_reg <= 1'b0;                                 // [R8] [R9]
            end

            // Capture flags; a blocked channel sets nothing
            if (cap1_edge & ~cap1_block_reg) begin
                cap1_flag_reg <= 1'b1;                                // [R15] [R22]
            end else if (cap1_armed_reg & acc_c1_lsb) begin
                cap1_flag_reg <= 1'b0;                                // [R18]
            end
            if (cap2_edge & ~cap2_block_reg) begin
                cap2_flag_reg <= 1'b1;                                // [R15] [R22]
            end else if (cap2_armed_reg & acc_c2_lsb) begin
                cap2_flag_reg <= 1'b0;                                // [R18]
            end

            // Arming drops once its flag is gone
            if (rd_status & ovf_flag_reg) begin
                ovf_armed_reg <= 1'b1;                                // [R8]
            end else if (acc_lsb | ~ovf_flag_reg) begin
                ovf_armed_reg <= 1'b0;
            end
            if (rd_status & cap1_flag_reg) begin
                cap1_armed_reg <= 1'b1;                               // [R18]
            end else if (acc_c1_lsb | ~cap1_flag_reg) begin
                cap1_armed_reg <= 1'b0;
            end
            if (rd_status & cap2_flag_reg) begin
                cap2_armed_reg <= 1'b1;                               // [R18]
            end else if (acc_c2_lsb | ~cap2_flag_reg) begin
                cap2_armed_reg <= 1'b0;
            end
        end
    end

    // Control registers
    // Only the low byte of the write data is used
    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_one_reg   <= `FRT_RESET_CTRL;
            ctrl_two_reg   <= `FRT_RESET_CTRL;
            ctrl_three_reg <= `FRT_RESET_CTRL;
        end else if (wr) begin
            if (hit(`FRT_OFS_CTRL_ONE)) begin
                ctrl_one_reg <= I_PWDATA[7:0];
            end
            if (hit(`FRT_OFS_CTRL_TWO)) begin
                ctrl_two_reg <= I_PWDATA[7:0];
            end
            if (hit(`FRT_OFS_CTRL_THREE)) begin
                ctrl_three_reg <= I_PWDATA[7:0];
            end
        end
    end

    // Read data is registered at the setup edge, so reads need no wait state
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (hit(`FRT_OFS_COUNT_MSB) | hit(`FRT_OFS_ALT_COUNT_MSB)) begin
            rd_byte = count_reg[15:8];                                // [R3]
        end else if (hit(`FRT_OFS_COUNT_LSB) | hit(`FRT_OFS_ALT_COUNT_LSB)) begin
            rd_byte = lsb_held_reg ? lsb_buf_reg : count_reg[7:0];    // [R3] [R4] [R5]
        end else if (hit(`FRT_OFS_CAP1_MSB)) begin
            rd_byte = cap1_reg[15:8];
        end else if (hit(`FRT_OFS_CAP1_LSB)) begin
            rd_byte = cap1_block_reg ? cap1_lsb_reg : cap1_reg[7:0];
        end else if (hit(`FRT_OFS_CAP2_MSB)) begin
            rd_byte = cap2_reg[15:8];
        end else if (hit(`FRT_OFS_CAP2_LSB)) begin
            rd_byte = cap2_block_reg ? cap2_lsb_reg : cap2_reg[7:0];
        end else if (hit(`FRT_OFS_STATUS)) begin
            rd_byte[`FRT_SR_CAP1] = cap1_flag_reg;
            rd_byte[`FRT_SR_CAP2] = cap2_flag_reg;
            rd_byte[`FRT_SR_OVF]  = ovf_flag_reg;
        end else if (hit(`FRT_OFS_CTRL_ONE)) begin
            rd_byte = ctrl_one_reg;
        end else if (hit(`FRT_OFS_CTRL_TWO)) begin
            rd_byte = ctrl_two_reg;
        end else if (hit(`FRT_OFS_CTRL_THREE)) begin
            rd_byte = ctrl_three_reg;
        end
    end


    // One wait-free access phase: ready follows every setup cycle
    reg ready_reg;
    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            prdata_reg <= 32'h0000_0000;
            ready_reg  <= 1'b0;
        end else begin
            ready_reg <= I_PSEL & ~I_PENABLE;
            if (I_PSEL & ~I_PENABLE) begin
                prdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign O_PRDATA  = prdata_reg;
    assign O_PREADY  = ready_reg;
    assign O_PSLVERR = access & ready_reg & ~mapped;
    assign O_COUNT   = count_reg;


    // Pending requests stay in the flags until enables allow them out
    // Compare requests arrive already flagged by the compare logic
    assign O_IRQ = ctrl_three_reg[`FRT_C3_GLOBAL_IE] &
                   ((ovf_flag_reg & ctrl_one_reg[`FRT_C1_OVF_IE]) |                      // [R7]
                    ((cap1_flag_reg | cap2_flag_reg) & ctrl_one_reg[`FRT_C1_CAP_IE]) |    // [R17]
                    I_COMPARE_IRQ);                                                       // [R21]
endmodule // frt_timer

// ---- tb/frt_timer_chk.sv ----
/* Checker for frt_timer: APB timing, counter loads and steps, halt, external clock, interrupt gating.
   Assumes it sees only the top ports and tracks control bits from the APB writes it observes. */
`timescale 1ns/10ps
`include "frt_defines.vh"
module frt_timer_chk (
    input wire        I_CLK_SYS,
    input wire        I_RESET_N,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    input wire        I_EXT_CLOCK_PIN,
    input wire        I_COMPARE_IRQ,
    input wire [15:0] O_COUNT,
    input wire        O_IRQ
);
    logic       acc, wr, wr_lsb, halt, gie, ext_q;
    logic [1:0] sel;
    logic [3:0] quiet;
    assign acc    = I_PSEL && I_PENABLE && O_PREADY;
    assign wr     = acc && I_PWRITE;
    assign wr_lsb = wr && (I_PADDR == `FRT_OFS_COUNT_LSB || I_PADDR == `FRT_OFS_ALT_COUNT_LSB);
    // Shadow of the control bits, updated at the same edge as the block's own registers
    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sel   <= 2'b00;
            halt  <= 1'b0;
            gie   <= 1'b0;
            ext_q <= 1'b0;
            quiet <= 4'h0;
        end else begin
            ext_q <= I_EXT_CLOCK_PIN;
            if (wr && I_PADDR == `FRT_OFS_CTRL_TWO)
                sel <= I_PWDATA[3:2];
            if (wr && I_PADDR == `FRT_OFS_CTRL_THREE) begin
                halt <= I_PWDATA[0];
                gie  <= I_PWDATA[7];
            end
            if (I_EXT_CLOCK_PIN != ext_q || wr)
                quiet <= 4'h0;
            else if (quiet != 4'hF)
                quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    a_pready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY) else $error("no ready after setup");
    a_pready_single: assert property (O_PREADY |=> !O_PREADY) else $error("ready held too long");
    a_unmapped_err: assert property (acc && I_PADDR > `FRT_OFS_CTRL_THREE |-> O_PSLVERR && O_PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_lsb_write_load: assert property (wr_lsb |=> O_COUNT == `FRT_COUNT_RESET) else $error("load missing");
    a_count_step_one: assert property (!$past(wr) && !halt && O_COUNT != $past(O_COUNT)
        |-> O_COUNT == $past(O_COUNT) + 16'h0001) else $error("counter jumped");
    a_halt_holds: assert property (halt && $past(halt) |-> O_COUNT == `FRT_COUNT_RESET) else $error("halt ignored");
    a_ext_quiet: assert property (sel == 2'b11 && quiet >= 4'd5 |-> $stable(O_COUNT)) else $error("count without edge");
    a_irq_gated: assert property (!gie |-> !O_IRQ) else $error("irq without global enable");
    a_compare_merge: assert property (gie && I_COMPARE_IRQ |-> O_IRQ) else $error("compare request lost");
    c_load: cover property (wr_lsb);
    c_ext_step: cover property (sel == 2'b11 && $changed(O_COUNT));
    c_irq: cover property (O_IRQ && !I_COMPARE_IRQ);
endmodule // frt_timer_chk

bind frt_timer frt_timer_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_EXT_CLOCK_PIN(I_EXT_CLOCK_PIN),
    .I_COMPARE_IRQ(I_COMPARE_IRQ), .O_COUNT(O_COUNT), .O_IRQ(O_IRQ));

// ---- tb/frt_pins_model.sv ----
/* Model of the pins feeding the timer: external count clock and two capture inputs.
   Assumes the bench calls its tasks; pins idle low and change just after a rising clock edge. */
`timescale 1ns/10ps
module frt_pins_model (
    input  wire  i_clk,
    output logic o_ext_clock_pin,
    output logic o_capture_pin_one,
    output logic o_capture_pin_two
);
    initial begin
        o_ext_clock_pin   = 1'b0;
        o_capture_pin_one = 1'b0;
        o_capture_pin_two = 1'b0;
    end
    // Four clocks per level keeps active edges eight clocks apart
    task automatic ext_toggles(input int n);
        for (int k = 0; k < n; k++) begin
            repeat (4) @(posedge i_clk);
            o_ext_clock_pin <= ~o_ext_clock_pin;
        end
    endtask
    task automatic cap_pulse(input int ch, input int hi);
        @(posedge i_clk);
        if (ch == 1) o_capture_pin_one <= 1'b1;
        else o_capture_pin_two <= 1'b1;
        repeat (hi) @(posedge i_clk);
        o_capture_pin_one <= 1'b0;
        o_capture_pin_two <= 1'b0;
    endtask
endmodule // frt_pins_model

// ---- tb/test_free_running_timer_capture.sv ----
/* Bench for frt_timer: APB byte accesses checking rates, buffered reads, overflow, capture, external clock.
   Assumes frt_pins_model drives the pins and the checker is bound to the design. */
`timescale 1ns/10ps
`include "frt_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_free_running_timer_capture;
    logic        clk, rst_n, psel, penable, pwrite, wait_mode, cmp_irq, pready, pslverr, irq, ext_pin, cap1, cap2, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] v, w, u;
    logic [7:0]  b;
    int          mismatches, compares, cyc, t0;
    frt_timer uut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_EXT_CLOCK_PIN(ext_pin), .I_CAPTURE_PIN_ONE(cap1), .I_CAPTURE_PIN_TWO(cap2), .I_WAIT_MODE(wait_mode),
        .I_COMPARE_IRQ(cmp_irq), .O_COUNT(), .O_IRQ(irq));
    frt_pins_model pins (.i_clk(clk), .o_ext_clock_pin(ext_pin), .o_capture_pin_one(cap1), .o_capture_pin_two(cap2));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        `CHK(pready, 1'b1)
        b = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd16(input logic [11:0] a);
        apb(1'b0, a, 8'h00);
        v[15:8] = b;
        apb(1'b0, a + 12'h004, 8'h00);
        v[7:0] = b;
    endtask
    task automatic start(input logic [7:0] c2);
        apb(1'b1, `FRT_OFS_CTRL_THREE, 8'h01);
        apb(1'b1, `FRT_OFS_CTRL_TWO, c2);
        apb(1'b1, `FRT_OFS_CTRL_THREE, 8'h00);
        t0 = cyc;
    endtask
    // Expected count from cycles elapsed since restart at the reset count
    function automatic logic [15:0] expc(input int div, input int ahead);
        return `FRT_COUNT_RESET + 16'((cyc + 1 + ahead - t0) / div);
    endfunction
    // Tolerates the unknown prescaler phase
    function automatic logic near(input logic [15:0] g, input logic [15:0] e);
        logic [15:0] d;
        d = g - e + 16'h0002;
        return d <= 16'h0004;
    endfunction
    initial begin
        #(25 * 20000);
        mismatches++;
        close_out();
    end
    initial begin
        {rst_n, psel, penable, pwrite, wait_mode, cmp_irq} = 6'b00_0000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, `FRT_OFS_CTRL_THREE, 8'h01);
        repeat (20) @(posedge clk);
        rd16(`FRT_OFS_COUNT_MSB);
        `CHK(v, 16'hFFFC)
        for (int s = 0; s < 3; s++) begin
            wait_mode <= (s == 2);
            start(8'(s << 2));
            repeat (100) @(posedge clk);
            w = expc(2 << s, 0);
            rd16(`FRT_OFS_COUNT_MSB);
            `CHK(near(v, w), 1'b1)
            w = expc(2 << s, 0);
            rd16(`FRT_OFS_ALT_COUNT_MSB);
            `CHK(near(v, w), 1'b1)
        end
        apb(1'b1, `FRT_OFS_CTRL_ONE, 8'h20);
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        `CHK(b[5], 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, `FRT_OFS_CTRL_THREE, 8'h80);
        apb(1'b0, `FRT_OFS_ALT_COUNT_LSB, 8'h00);
        `CHK(irq, 1'b1)
        apb(1'b0, `FRT_OFS_ALT_COUNT_LSB, 8'h00);
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        apb(1'b1, `FRT_OFS_ALT_COUNT_LSB, 8'h00);
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        `CHK(b[5], 1'b1)
        t0 = cyc;
        apb(1'b0, `FRT_OFS_COUNT_LSB, 8'h00);
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        `CHK(b[5], 1'b0)
        `CHK(irq, 1'b0)
        cmp_irq <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        cmp_irq <= 1'b0;
        w = expc(8, 0);
        rd16(`FRT_OFS_ALT_COUNT_MSB);
        `CHK(near(v, w), 1'b1)
        apb(1'b0, `FRT_OFS_COUNT_MSB, 8'h00);
        w = expc(8, -4);
        repeat (200) @(posedge clk);
        apb(1'b0, `FRT_OFS_COUNT_MSB, 8'h00);
        apb(1'b0, `FRT_OFS_COUNT_LSB, 8'h00);
        `CHK(near({w[15:8], b}, w), 1'b1)
        w = expc(8, 0);
        apb(1'b0, `FRT_OFS_COUNT_LSB, 8'h00);
        `CHK(near({w[15:8], b}, w), 1'b1)
        for (int e = 1; e >= 0; e--) begin
            apb(1'b1, `FRT_OFS_CTRL_TWO, {7'h06, e[0]});
            apb(1'b1, `FRT_OFS_COUNT_LSB, 8'h00);
            pins.ext_toggles(5);
            repeat (8) @(posedge clk);
            rd16(`FRT_OFS_COUNT_MSB);
            `CHK(v, 16'hFFFC + 16'(2 + e))
            pins.ext_toggles(1);
        end
        start(8'h08);
        apb(1'b1, `FRT_OFS_CTRL_ONE, 8'h82);
        repeat (40) @(posedge clk);
        w = expc(8, 0);
        pins.cap_pulse(1, 4);
        rd16(`FRT_OFS_CAP1_MSB);
        `CHK(near(v, w), 1'b1)
        u = v;
        w = expc(8, 40);
        pins.cap_pulse(2, 40);
        rd16(`FRT_OFS_CAP2_MSB);
        `CHK(near(v, w), 1'b1)
        apb(1'b0, `FRT_OFS_CAP1_MSB, 8'h00);
        pins.cap_pulse(1, 4);
        apb(1'b0, `FRT_OFS_CAP1_LSB, 8'h00);
        `CHK(b, u[7:0])
        rd16(`FRT_OFS_CAP1_MSB);
        `CHK(v, u)
        w = expc(8, 0);
        pins.cap_pulse(1, 4);
        rd16(`FRT_OFS_CAP1_MSB);
        `CHK(near(v, w), 1'b1)
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        `CHK(b[7:6], 2'b11)
        `CHK(irq, 1'b0)
        apb(1'b1, `FRT_OFS_CTRL_THREE, 8'h80);
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        `CHK(irq, 1'b1)
        apb(1'b0, `FRT_OFS_CAP1_LSB, 8'h00);
        apb(1'b0, `FRT_OFS_CAP2_LSB, 8'h00);
        apb(1'b0, `FRT_OFS_STATUS, 8'h00);
        `CHK(b[7:6], 2'b00)
        `CHK(irq, 1'b0)
        apb(1'b0, 12'h100, 8'h00);
        `CHK({err, b}, 9'h100)
        close_out();
    end
endmodule // test_free_running_timer_capture
